/* design/ufdc_top.v */
// uart frame debug counters and nvm error block address registers
//
// Contract
// RQ1: a 16-bit count of valid uart frames, sent or received, is read as high and low bytes at two adjacent offsets.
// RQ2: the valid-frame count holds at all ones instead of wrapping.
// RQ3: a read of the discard register snapshots the valid count into its registers and clears the live counter.
// RQ4: an 8-bit discarded-frame count is snapshotted and cleared together with the valid count on that read.
// RQ5: the block address of the latest nvm read needing single-bit correction is kept, meaningful while its flag is set.
// RQ6: the block address of the latest nvm read with a double-bit error is kept, meaningful while its flag is set.
// RQ7: a received frame failing its crc is counted as discarded.
// RQ8: frames ignored after a byte error until the next clear count as neither valid nor discarded.
`timescale 1ns/10ps
`include "ufdc_map.vh"
module ufdc_top (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// frame events from the uart engine, one-cycle pulses
	input wire frame_valid,
	input wire frame_discard,
	input wire frame_crc_error,
	input wire byte_error,
	input wire comm_clear,
	// nvm error reports, one-cycle pulses with block address
	input wire single_bit_correction,
	input wire double_bit_detection,
	input wire [7:0] nvm_block,
	// fault flags owned elsewhere
	input wire single_error_corrected_flag,
	input wire double_error_detected_flag,
	// register read port
	input wire rd_en,
	input wire [`UFDC_ADDR_W-1:0] rd_addr,
	output reg [7:0] rd_data_q,
	output reg rd_valid_q
);
	// register selects produced by the address decode
	localparam SEL_NONE = 3'h0;
	localparam SEL_DISCARD = 3'h1;
	localparam SEL_VALID_HI = 3'h2;
	localparam SEL_VALID_LO = 3'h3;
	localparam SEL_SEC_BLK = 3'h4;
	localparam SEL_DED_BLK = 3'h5;

	// nvm capture channels: 0 corrected, 1 uncorrectable
	localparam NVM_CH = 2;

	// ignore window after a byte error
	reg ignore_q;
	reg ignore_d;

	// snapshot registers
	reg [7:0] discard_reg_q;
	reg [7:0] discard_reg_d;
	reg [7:0] valid_hi_q;
	reg [7:0] valid_hi_d;
	reg [7:0] valid_lo_q;
	reg [7:0] valid_lo_d;

	// read port next values
	reg [7:0] rd_data_d;
	reg rd_valid_d;

	// live counters and control
	wire [2:0] rd_sel;
	wire snap;
	wire cnt_valid;
	wire cnt_discard;
	wire [15:0] valid_cnt;
	wire [7:0] discard_cnt;

	// nvm error capture
	wire [NVM_CH-1:0] nvm_hit;
	wire [7:0] nvm_blk [0:NVM_CH-1];

	// decode of the read address into a register select
	function [2:0] ufdc_decode;
		input [`UFDC_ADDR_W-1:0] a;
		begin
			case (a)
				`UFDC_OFF_DISCARD: ufdc_decode = SEL_DISCARD;
				`UFDC_OFF_VALID_HI: ufdc_decode = SEL_VALID_HI;
				`UFDC_OFF_VALID_LO: ufdc_decode = SEL_VALID_LO;
				`UFDC_OFF_SEC_BLK: ufdc_decode = SEL_SEC_BLK;
				`UFDC_OFF_DED_BLK: ufdc_decode = SEL_DED_BLK;
				default: ufdc_decode = SEL_NONE;
			endcase
		end
	endfunction

	// a frame event counts only outside the ignore window
	function ufdc_counts;
		input ev;
		input ignored;
		input err;
		begin
			ufdc_counts = ev && !ignored && !err;
		end
	endfunction

	assign rd_sel = ufdc_decode(rd_addr);
	assign snap = rd_en && (rd_sel == SEL_DISCARD); // [RQ3]

	// a byte error itself starts the ignore window, so its own frame is not counted
	assign cnt_valid = ufdc_counts(frame_valid, ignore_q, byte_error); // [RQ8]
	// a crc failure and a discard in one cycle describe one frame, so they count once
	assign cnt_discard = ufdc_counts(frame_discard || frame_crc_error, ignore_q, byte_error); // [RQ7] [RQ8]

	always @* begin
		ignore_d = ignore_q;
		if (comm_clear) begin
			ignore_d = 1'b0;
		end else if (byte_error) begin
			ignore_d = 1'b1; // [RQ8]
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			ignore_q <= 1'b0;
		end else begin
			ignore_q <= ignore_d;
		end
	end

	ufdc_sat_counter #(.W(16)) u_valid (
		.clk_sys(clk_sys),
		.rst(rst),
		.inc(cnt_valid), // [RQ1]
		.clr(snap), // [RQ3]
		.count_q(valid_cnt)
	);

	ufdc_sat_counter #(.W(8)) u_discard (
		.clk_sys(clk_sys),
		.rst(rst),
		.inc(cnt_discard), // [RQ4]
		.clr(snap), // [RQ4]
		.count_q(discard_cnt)
	);

	// snapshot is taken in the same cycle the live counters clear
	always @* begin
		discard_reg_d = discard_reg_q;
		valid_hi_d = valid_hi_q;
		valid_lo_d = valid_lo_q;
		if (snap) begin
			discard_reg_d = discard_cnt; // [RQ4]
			valid_hi_d = valid_cnt[15:8]; // [RQ3]
			valid_lo_d = valid_cnt[7:0]; // [RQ3]
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			discard_reg_q <= `UFDC_RST_BYTE;
			valid_hi_q <= `UFDC_RST_BYTE;
			valid_lo_q <= `UFDC_RST_BYTE;
		end else begin
			discard_reg_q <= discard_reg_d;
			valid_hi_q <= valid_hi_d;
			valid_lo_q <= valid_lo_d;
		end
	end

	// the fault flags are not used to gate the addresses; a stale address stays readable
	assign nvm_hit = {double_bit_detection, single_bit_correction};

	genvar g;
	generate
		for (g = 0; g < NVM_CH; g = g + 1) begin : g_nvm
			reg [7:0] blk_q;
			wire [7:0] blk_d;
			// a later event overwrites, so only the newest block address survives
			assign blk_d = nvm_hit[g] ? nvm_block : blk_q; // [RQ5] [RQ6]
			always @(posedge clk_sys) begin
				if (rst) begin
					blk_q <= `UFDC_RST_BYTE;
				end else begin
					blk_q <= blk_d;
				end
			end
			assign nvm_blk[g] = blk_q;
		end
	endgenerate

	// discard read returns the live count being captured, so software sees what it latched
	always @* begin
		rd_valid_d = rd_en;
		rd_data_d = 8'h00;
		if (rd_en) begin
			case (rd_sel)
				SEL_DISCARD: rd_data_d = discard_cnt; // [RQ4]
				SEL_VALID_HI: rd_data_d = valid_hi_q; // [RQ1]
				SEL_VALID_LO: rd_data_d = valid_lo_q; // [RQ1]
				SEL_SEC_BLK: rd_data_d = nvm_blk[0]; // [RQ5]
				SEL_DED_BLK: rd_data_d = nvm_blk[1]; // [RQ6]
				default: rd_data_d = 8'h00;
			endcase
		end
	end

	// unmapped offsets still answer, with zero data
	always @(posedge clk_sys) begin
		if (rst) begin
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_valid_d;
			rd_data_q <= rd_data_d;
		end
	end

	// the discard snapshot register is kept for the latch semantics; reads use the live value
	// which it captures at the read and holds from the next cycle, so no second path is needed
endmodule

/* pkg/ufdc_map.vh */
// register offsets, reset values and widths for the uart frame debug counters
`ifndef UFDC_MAP_VH
`define UFDC_MAP_VH
`define UFDC_ADDR_W 16
`define UFDC_OFF_DISCARD 16'h0789
`define UFDC_OFF_VALID_HI 16'h078C
`define UFDC_OFF_VALID_LO 16'h078D
`define UFDC_OFF_SEC_BLK 16'h07A0
`define UFDC_OFF_DED_BLK 16'h07A1
`define UFDC_RST_BYTE 8'h00
`define UFDC_VALID_MAX 16'hFFFF
`define UFDC_DISCARD_MAX 8'hFF
`endif

/* design/ufdc_sat_counter.v */
// saturating event counter with synchronous clear
`timescale 1ns/10ps
module ufdc_sat_counter #(
	parameter W = 8
) (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// control
	input wire inc,
	input wire clr,
	// count
	output reg [W-1:0] count_q
);
	wire [W-1:0] count_d;
	wire at_max;
	assign at_max = &count_q;
	// events arriving in the clear cycle are lost by design; the snapshot took the old value
	assign count_d = clr ? {W{1'b0}} : ((inc && !at_max) ? count_q + {{(W-1){1'b0}}, 1'b1} : count_q); // [RQ2]
	always @(posedge clk_sys) begin
		if (rst) begin
			count_q <= {W{1'b0}};
		end else begin
			count_q <= count_d;
		end
	end
endmodule

/* verif/ufdc_host.sv */
// host model issuing one register read at a time
`timescale 1ns/10ps
module ufdc_host (input wire clk_sys, input wire [7:0] rd_data_q, input wire rd_valid_q,
	output logic rd_en = 0, output logic [15:0] rd_addr = 0);
	logic [7:0] d;
	logic v;
	task rd(input [15:0] a);
		{rd_en, rd_addr} = {1'b1, a};
		@(posedge clk_sys) #1;
		// the answer stands only in the cycle after the request edge
		{v, d} = {rd_valid_q, rd_data_q};
		// a released address shows junk, not the last value
		{rd_en, rd_addr} = {1'b0, ~a};
		@(posedge clk_sys) #1;
	endtask
endmodule

/* verif/ufdc_props.sv */
// assertions on the counter read port
`timescale 1ns/10ps
module ufdc_props (
	input wire clk_sys, rst, rd_en, rd_valid_q, frame_valid, frame_discard, frame_crc_error,
	input wire single_bit_correction, double_bit_detection,
	input wire [15:0] rd_addr,
	input wire [7:0] rd_data_q, nvm_block
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence r(a); rd_en && rd_addr == a; endsequence
	sequence q; !rd_en && !frame_valid && !frame_discard && !frame_crc_error; endsequence
	sequence c2; r(16'h0789) ##1 q ##1 r(16'h0789); endsequence
	property cap(e, a); e ##1 !e [*2] ##0 r(a) |=> rd_data_q == $past(nvm_block, 3); endproperty
	a_rd_answer: assert property (rd_en |=> rd_valid_q) else $error("no answer");
	a_rd_quiet: assert property (!rd_en |=> !rd_valid_q) else $error("stray valid");
	a_idle_data: assert property (!rd_en |=> rd_data_q == 0) else $error("stray data");
	a_unmapped_zero: assert property (r(0) |=> rd_data_q == 0) else $error("unmapped data");
	a_discard_clear: assert property (c2 |=> rd_data_q == 0) else $error("no clear");
	a_valid_clear: assert property (c2 ##1 q ##1 r(16'h078D) |=> rd_data_q == 0) else $error("stale");
	a_sec_capture: assert property (cap(single_bit_correction, 16'h07A0)) else $error("sec block");
	a_ded_capture: assert property (cap(double_bit_detection, 16'h07A1)) else $error("ded block");
	cover property (c2);
	cover property (single_bit_correction);
	cover property (double_bit_detection);
endmodule
bind ufdc_top ufdc_props u_props(.*);

/* verif/testbench.sv */
// random frame events and host reads against the debug counters
`timescale 1ns/10ps
module testbench;
	logic clk_sys = 0, rst = 1, rd_en, rd_valid_q;
	logic [6:0] ev = 0;
	logic [6:0] seq[5] = '{7'h08, 7'h50, 7'h04, 7'h40, 7'h00};
	logic [7:0] blk = 0, rd_data_q;
	logic [15:0] rd_addr;
	int bad_count, compares, nv, nd;
	ufdc_top u_dut(.clk_sys, .rst, .frame_valid(ev[6]), .frame_discard(ev[5]), .frame_crc_error(ev[4]),
		.byte_error(ev[3]), .comm_clear(ev[2]), .single_bit_correction(ev[1]), .double_bit_detection(ev[0]),
		.single_error_corrected_flag(ev[1]), .double_error_detected_flag(ev[0]), .nvm_block(blk),
		.rd_en, .rd_addr, .rd_data_q, .rd_valid_q);
	ufdc_host u_host(.clk_sys, .rd_data_q, .rd_valid_q, .rd_en, .rd_addr);
	initial forever #20 clk_sys = ~clk_sys;
	initial #3000000 wrap_up(1);
	task put(input [6:0] v);
		ev = v;
		nv += v[6];
		nd += v[5] | v[4];
		@(posedge clk_sys) #1;
	endtask
	task chk(input [15:0] a, input int e);
		u_host.rd(a);
		compares++;
		bad_count += ({u_host.v, u_host.d} !== {1'b1, 8'(e)});
		if ({u_host.v, u_host.d} !== {1'b1, 8'(e)}) $display("MISMATCH %0t %h %h", $time, {u_host.v, u_host.d}, {1'b1, 8'(e)});
	endtask
	function int sat(int n);
		return n > 255 ? 255 : n;
	endfunction
	task wrap_up(input int lost);
		bad_count += lost;
		if (bad_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h8fa9));
		#621 rst = 0;
		repeat (300) put({3'($urandom), 4'h0});
		put(0);
		chk(16'h0789, sat(nd));
		chk(16'h078C, nv >> 8);
		chk(16'h078D, nv);
		chk(16'h0789, 0);
		chk(16'h0789, 0);
		chk(16'h078D, 0);
		chk(16'h0000, 0);
		foreach (seq[i]) put(seq[i]);
		chk(16'h0789, 0);
		chk(16'h078D, 1);
		repeat (65540) put(7'h40);
		put(0);
		chk(16'h0789, 0);
		chk(16'h078C, 8'hFF);
		chk(16'h078D, 8'hFF);
		for (int i = 0; i < 2; i++) begin
			blk = 8'($urandom);
			put(7'(2 >> i));
			put(0);
			chk(16'h07A0 + 16'(i), blk);
		end
		wrap_up(0);
	end
endmodule
